// *** hdl/mts_map.svh ***
`ifndef MTS_MAP_SVH
`define MTS_MAP_SVH

// Register byte offsets
`define MTS_CTRL_OFFSET 8'h00
`define MTS_SCOUNT_OFFSET 8'h04
`define MTS_PRETRIG_OFFSET 8'h08
`define MTS_DELAY_OFFSET 8'h0C
`define MTS_MEASCFG_OFFSET 8'h10
`define MTS_STATUS_OFFSET 8'h14
`define MTS_EFFDELAY_OFFSET 8'h18
`define MTS_INTERVAL_OFFSET 8'h1C

// Control fields
`define MTS_CTRL_ARM 0
`define MTS_CTRL_BUSTRIG 1
`define MTS_CTRL_SRC_LO 2
`define MTS_CTRL_EXT_FALL 4
`define MTS_CTRL_COMP_FALL 5
`define MTS_CTRL_TIMED 6
`define MTS_CTRL_MANUAL 7
`define MTS_CTRL_LOCAL 8
`define MTS_CTRL_RESET 9'h030
`define MTS_SCOUNT_RESET 20'h0_0001

// Limits
`define MTS_MAX_SAMPLES 32'h000F_4240
`define MTS_MAX_DELAY_US 32'hD693_A400

// Timebase
`define MTS_CLK_MHZ 8'h7D
`define MTS_US_CYCLES 32'h0000_007D
`define MTS_COMP_PULSE_NS 32'h0000_03E8
`define MTS_CLK_PERIOD_NS 32'h0000_0008
`define MTS_COMP_PULSE_CYCLES ((`MTS_COMP_PULSE_NS + `MTS_CLK_PERIOD_NS - 32'h0000_0001) / `MTS_CLK_PERIOD_NS)

// Automatic delays in microseconds
`define MTS_DLY_LOCAL_US 32'h0000_C350
`define MTS_DLY_DCV_LONG_US 32'h0000_00A0
`define MTS_DLY_DCV_MID_US 32'h0000_0082
`define MTS_DLY_DCV_SHORT_US 32'h0000_0064
`define MTS_DLY_DCI_LONG_US 32'h0000_05DC
`define MTS_DLY_DCI_SHORT_US 32'h0000_03E8
`define MTS_DLY_R2_100_S_US 32'h0000_0050
`define MTS_DLY_R2_100_M_US 32'h0000_0064
`define MTS_DLY_R2_100_L_US 32'h0000_0082
`define MTS_DLY_R2_1K_S_US 32'h0000_006E
`define MTS_DLY_R2_1K_M_US 32'h0000_0082
`define MTS_DLY_R2_1K_L_US 32'h0000_00A0
`define MTS_DLY_R2_10K_S_US 32'h0000_0082
`define MTS_DLY_R2_10K_M_US 32'h0000_00A0
`define MTS_DLY_R2_10K_L_US 32'h0000_00BE
`define MTS_DLY_R2_100K_S_US 32'h0000_021C
`define MTS_DLY_R2_100K_M_US 32'h0000_029E
`define MTS_DLY_R2_100K_L_US 32'h0000_0320
`define MTS_DLY_R2_1M_S_US 32'h0000_1388
`define MTS_DLY_R2_1M_M_US 32'h0000_1770
`define MTS_DLY_R2_1M_L_US 32'h0000_1D4C
`define MTS_DLY_R2_HI_S_US 32'h0000_EA60
`define MTS_DLY_R2_HI_M_US 32'h0001_1170
`define MTS_DLY_R2_HI_L_US 32'h0001_4820
`define MTS_DLY_R4_LO_S_US 32'h0000_03E8
`define MTS_DLY_R4_LO_L_US 32'h0000_05DC
`define MTS_DLY_R4_1M_S_US 32'h0000_2710
`define MTS_DLY_R4_1M_L_US 32'h0000_3A98
`define MTS_DLY_R4_HI_US 32'h0001_86A0
`define MTS_DLY_CAP_US 32'h0000_0000
`define MTS_DLY_ACV_SLOW_US 32'h0026_25A0
`define MTS_DLY_ACV_MED_US 32'h0009_8968
`define MTS_DLY_ACV_FAST_US 32'h0000_61A8
`define MTS_DLY_ACI_SLOW_US 32'h0019_5460
`define MTS_DLY_ACI_MED_US 32'h0003_D090
`define MTS_DLY_ACI_FAST_US 32'h0000_61A8
`define MTS_DLY_FREQ_US 32'h000F_4240

`endif

// *** hdl/mts_pkg.sv ***
package mts_pkg;
  typedef enum logic [2:0] {
    MTS_IDLE = 3'h0,
    MTS_WAIT = 3'h1,
    MTS_DELAY = 3'h3,
    MTS_MEAS = 3'h2,
    MTS_SPACE = 3'h6
  } mts_state_type;

  typedef enum logic [1:0] {
    MTS_SRC_IMM = 2'h0,
    MTS_SRC_BUS = 2'h1,
    MTS_SRC_EXT = 2'h2
  } mts_src_type;

  typedef enum logic [3:0] {
    MTS_FN_DCV = 4'h0,
    MTS_FN_DCI = 4'h1,
    MTS_FN_RES2 = 4'h2,
    MTS_FN_RES4 = 4'h3,
    MTS_FN_CAP = 4'h4,
    MTS_FN_ACV = 4'h5,
    MTS_FN_ACI = 4'h6,
    MTS_FN_TEMP2 = 4'h7,
    MTS_FN_TEMP4 = 4'h8,
    MTS_FN_FREQ = 4'h9
  } mts_func_type;
endpackage

// *** hdl/mts_top.sv ***
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "mts_map.svh"

module mts_top #(
  parameter logic [31:0] US_TICK_CYCLES = `MTS_US_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Trigger handshake
  input wire logic ext_trigger_in,
  output logic measurement_complete_output,
  output logic waiting_for_trigger,
  // Converter
  output logic sample_start,
  output logic sample_pretrigger,
  input wire logic sample_done,
  input wire logic [2:0] autorange_range
);
  import mts_pkg::*;

  logic aw_held_reg, w_held_reg, awready_reg, wready_reg, bvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic arready_reg, rvalid_reg;
  logic [8:0] ctrl_reg;
  logic [19:0] scount_reg, pretrig_reg, left_reg, pre_have_reg;
  logic [31:0] delay_reg, interval_reg, eff_delay_reg, delay_left_reg, prescale_reg;
  logic [3:0] func_reg;
  logic [2:0] range_reg;
  logic [1:0] integ_reg, filter_reg;
  logic reject_reg, bustrig_reg, ext_prev_reg, pending_reg, issued_reg, pre_busy_reg;
  logic comp_level_reg, waiting_reg, start_reg, start_pre_reg;
  logic [7:0] comp_cnt_reg;
  mts_state_type state_reg;
  logic wr_fire, wr_ok, wr_map, ext_edge, trig_now, take, us_tick, done_meas;
  logic [31:0] auto_us;
  mts_src_type src;

  function automatic logic [31:0] pick3(input logic [1:0] ic, input logic [31:0] s, input logic [31:0] m,
                                        input logic [31:0] l);
    pick3 = (ic == 2'h0) ? s : ((ic == 2'h1) ? m : l);
  endfunction

  // Range codes 0..6 stand for 100 ohm up to the top decade
  function automatic logic [31:0] res_delay(input logic four, input logic [2:0] rng, input logic [1:0] ic);
    if (four) begin
      if (rng <= 3'h3) res_delay = pick3(ic, `MTS_DLY_R4_LO_S_US, `MTS_DLY_R4_LO_S_US, `MTS_DLY_R4_LO_L_US);
      else if (rng == 3'h4) res_delay = pick3(ic, `MTS_DLY_R4_1M_S_US, `MTS_DLY_R4_1M_S_US, `MTS_DLY_R4_1M_L_US);
      else res_delay = `MTS_DLY_R4_HI_US;
    end else begin
      case (rng)
        3'h0: res_delay = pick3(ic, `MTS_DLY_R2_100_S_US, `MTS_DLY_R2_100_M_US, `MTS_DLY_R2_100_L_US);
        3'h1: res_delay = pick3(ic, `MTS_DLY_R2_1K_S_US, `MTS_DLY_R2_1K_M_US, `MTS_DLY_R2_1K_L_US);
        3'h2: res_delay = pick3(ic, `MTS_DLY_R2_10K_S_US, `MTS_DLY_R2_10K_M_US, `MTS_DLY_R2_10K_L_US);
        3'h3: res_delay = pick3(ic, `MTS_DLY_R2_100K_S_US, `MTS_DLY_R2_100K_M_US, `MTS_DLY_R2_100K_L_US);
        3'h4: res_delay = pick3(ic, `MTS_DLY_R2_1M_S_US, `MTS_DLY_R2_1M_M_US, `MTS_DLY_R2_1M_L_US);
        default: res_delay = pick3(ic, `MTS_DLY_R2_HI_S_US, `MTS_DLY_R2_HI_M_US, `MTS_DLY_R2_HI_L_US);
      endcase
    end
  endfunction

  // Integration class: 0 short, 1 middle, 2 and up long; filter: 0 slow, 1 medium, 2 and up fast
  always_comb begin
    if (ctrl_reg[`MTS_CTRL_LOCAL]) begin
      auto_us = `MTS_DLY_LOCAL_US;
    end else begin
      case (func_reg)
        MTS_FN_DCV: auto_us = pick3(integ_reg, `MTS_DLY_DCV_SHORT_US, `MTS_DLY_DCV_MID_US, `MTS_DLY_DCV_LONG_US);
        MTS_FN_DCI: auto_us = pick3(integ_reg, `MTS_DLY_DCI_SHORT_US, `MTS_DLY_DCI_SHORT_US, `MTS_DLY_DCI_LONG_US);
        MTS_FN_RES2: auto_us = res_delay(1'b0, range_reg, integ_reg);
        MTS_FN_RES4: auto_us = res_delay(1'b1, range_reg, integ_reg);
        MTS_FN_CAP: auto_us = `MTS_DLY_CAP_US;
        MTS_FN_ACV: auto_us = pick3(filter_reg, `MTS_DLY_ACV_SLOW_US, `MTS_DLY_ACV_MED_US, `MTS_DLY_ACV_FAST_US);
        MTS_FN_ACI: auto_us = pick3(filter_reg, `MTS_DLY_ACI_SLOW_US, `MTS_DLY_ACI_MED_US, `MTS_DLY_ACI_FAST_US);
        MTS_FN_TEMP2: auto_us = res_delay(1'b0, autorange_range, integ_reg);
        MTS_FN_TEMP4: auto_us = res_delay(1'b1, autorange_range, integ_reg);
        MTS_FN_FREQ: auto_us = `MTS_DLY_FREQ_US;
        default: auto_us = `MTS_DLY_FREQ_US;
      endcase
    end
  end

  // Delay in effect, registered so it can be read back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eff_delay_reg <= 32'h0000_0000;
    end else begin
      eff_delay_reg <= ctrl_reg[`MTS_CTRL_MANUAL] ? delay_reg : auto_us;
    end
  end

  // AXI write channels; address and data are taken in either order
  assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awready_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (s_axi_awvalid && awready_reg) begin
      aw_held_reg <= 1'b1;
      awready_reg <= 1'b0;
      awaddr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
      awready_reg <= 1'b1;
    end else if (!aw_held_reg) begin
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wready_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && wready_reg) begin
      w_held_reg <= 1'b1;
      wready_reg <= 1'b0;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
      wready_reg <= 1'b1;
    end else if (!w_held_reg) begin
      wready_reg <= 1'b1;
    end
  end

  // Partial writes are refused as a whole: the fields are not byte aligned
  always_comb begin
    wr_map = 1'b1;
    wr_ok = (wstrb_reg == 4'hF);
    case (awaddr_reg)
      `MTS_CTRL_OFFSET, `MTS_MEASCFG_OFFSET, `MTS_INTERVAL_OFFSET, `MTS_STATUS_OFFSET: wr_ok = wr_ok;
      `MTS_SCOUNT_OFFSET: wr_ok = wr_ok && (wdata_reg != 32'h0000_0000) && (wdata_reg <= `MTS_MAX_SAMPLES)
                                  && ({12'h000, pretrig_reg} < wdata_reg);
      `MTS_PRETRIG_OFFSET: wr_ok = wr_ok && (wdata_reg < {12'h000, scount_reg});
      `MTS_DELAY_OFFSET: wr_ok = wr_ok && (wdata_reg <= `MTS_MAX_DELAY_US);
      default: begin
        wr_map = 1'b0;
        wr_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_ok ? 2'h0 : (wr_map ? 2'h2 : 2'h3);
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `MTS_CTRL_RESET;
      scount_reg <= `MTS_SCOUNT_RESET;
      pretrig_reg <= 20'h0_0000;
      delay_reg <= 32'h0000_0000;
      interval_reg <= 32'h0000_0000;
      func_reg <= 4'h0;
      range_reg <= 3'h0;
      integ_reg <= 2'h2;
      filter_reg <= 2'h1;
      bustrig_reg <= 1'b0;
    end else begin
      bustrig_reg <= 1'b0;
      if (wr_fire && wr_ok) begin
        case (awaddr_reg)
          `MTS_CTRL_OFFSET: begin
            ctrl_reg <= wdata_reg[8:0] & 9'h1FD;
            bustrig_reg <= wdata_reg[`MTS_CTRL_BUSTRIG];
          end
          `MTS_SCOUNT_OFFSET: scount_reg <= wdata_reg[19:0];
          `MTS_PRETRIG_OFFSET: pretrig_reg <= wdata_reg[19:0];
          `MTS_DELAY_OFFSET: delay_reg <= wdata_reg;
          `MTS_MEASCFG_OFFSET: begin
            func_reg <= wdata_reg[3:0];
            range_reg <= wdata_reg[6:4];
            integ_reg <= wdata_reg[9:8];
            filter_reg <= wdata_reg[11:10];
          end
          `MTS_INTERVAL_OFFSET: interval_reg <= wdata_reg;
          default: bustrig_reg <= 1'b0;
        endcase
      end
    end
  end

  // Refused-write flag; write one to clear, a new refusal wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reject_reg <= 1'b0;
    end else if (wr_fire && !wr_ok && wr_map) begin
      reject_reg <= 1'b1;
    end else if (wr_fire && wr_ok && awaddr_reg == `MTS_STATUS_OFFSET && wdata_reg[0]) begin
      reject_reg <= 1'b0;
    end
  end

  // AXI read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= 2'h0;
      case (s_axi_araddr)
        `MTS_CTRL_OFFSET: rdata_reg <= {23'h00_0000, ctrl_reg};
        `MTS_SCOUNT_OFFSET: rdata_reg <= {12'h000, scount_reg};
        `MTS_PRETRIG_OFFSET: rdata_reg <= {12'h000, pretrig_reg};
        `MTS_DELAY_OFFSET: rdata_reg <= delay_reg;
        `MTS_MEASCFG_OFFSET: rdata_reg <= {20'h0_0000, filter_reg, integ_reg, 1'b0, range_reg, func_reg};
        `MTS_STATUS_OFFSET: rdata_reg <= {25'h000_0000, pending_reg, waiting_reg, state_reg, 1'b0, reject_reg}
                                         | {12'h000, left_reg};
        `MTS_EFFDELAY_OFFSET: rdata_reg <= eff_delay_reg;
        `MTS_INTERVAL_OFFSET: rdata_reg <= interval_reg;
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= 2'h3;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end

  // Trigger detection
  assign src = mts_src_type'(ctrl_reg[3:2]);
  assign ext_edge = (src == MTS_SRC_EXT) && ctrl_reg[`MTS_CTRL_ARM]
                    && (ctrl_reg[`MTS_CTRL_EXT_FALL] ? (ext_prev_reg & ~ext_trigger_in)
                                                     : (~ext_prev_reg & ext_trigger_in));
  always_comb begin
    case (src)
      MTS_SRC_IMM: trig_now = 1'b1;
      MTS_SRC_BUS: trig_now = bustrig_reg;
      MTS_SRC_EXT: trig_now = ext_edge | pending_reg;
      default: trig_now = 1'b0;
    endcase
  end
  // A pre-trigger sample in flight holds off the trigger; the edge is then kept as pending
  assign take = (state_reg == MTS_WAIT) && ctrl_reg[`MTS_CTRL_ARM] && !pre_busy_reg && trig_now;
  assign us_tick = (prescale_reg >= US_TICK_CYCLES - 32'h0000_0001);
  assign done_meas = (state_reg == MTS_MEAS) && issued_reg && sample_done;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_prev_reg <= 1'b1;
      pending_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_trigger_in;
      if (!ctrl_reg[`MTS_CTRL_ARM] || src != MTS_SRC_EXT) begin
        pending_reg <= 1'b0;
      end else if (take) begin
        pending_reg <= pending_reg & ext_edge;
      end else if (ext_edge) begin
        pending_reg <= 1'b1;
      end
    end
  end

  // Sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= MTS_IDLE;
      left_reg <= 20'h0_0000;
      pre_have_reg <= 20'h0_0000;
      delay_left_reg <= 32'h0000_0000;
      prescale_reg <= 32'h0000_0000;
      issued_reg <= 1'b0;
      pre_busy_reg <= 1'b0;
      start_reg <= 1'b0;
      start_pre_reg <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      prescale_reg <= us_tick ? 32'h0000_0000 : prescale_reg + 32'h0000_0001;
      case (state_reg)
        MTS_IDLE: begin
          pre_have_reg <= 20'h0_0000;
          if (ctrl_reg[`MTS_CTRL_ARM]) state_reg <= MTS_WAIT;
        end
        MTS_WAIT: begin
          if (!ctrl_reg[`MTS_CTRL_ARM] && !pre_busy_reg) begin
            state_reg <= MTS_IDLE;
          end else if (take) begin
            left_reg <= scount_reg - pre_have_reg;
            pre_have_reg <= 20'h0_0000;
            delay_left_reg <= eff_delay_reg;
            prescale_reg <= 32'h0000_0000;
            state_reg <= MTS_DELAY;
          end else if (pre_busy_reg) begin
            if (sample_done) begin
              pre_busy_reg <= 1'b0;
              if (pre_have_reg < pretrig_reg) pre_have_reg <= pre_have_reg + 20'h0_0001;
            end
          end else if (pretrig_reg != 20'h0_0000 && ctrl_reg[`MTS_CTRL_ARM]) begin
            pre_busy_reg <= 1'b1;
            start_reg <= 1'b1;
            start_pre_reg <= 1'b1;
          end
        end
        MTS_DELAY, MTS_SPACE: begin
          if (delay_left_reg == 32'h0000_0000) begin
            state_reg <= MTS_MEAS;
            issued_reg <= 1'b0;
          end else if (us_tick) begin
            delay_left_reg <= delay_left_reg - 32'h0000_0001;
          end
        end
        MTS_MEAS: begin
          if (!issued_reg) begin
            issued_reg <= 1'b1;
            start_reg <= 1'b1;
            start_pre_reg <= 1'b0;
          end else if (done_meas) begin
            left_reg <= left_reg - 20'h0_0001;
            prescale_reg <= 32'h0000_0000;
            if (left_reg <= 20'h0_0001) begin
              state_reg <= ctrl_reg[`MTS_CTRL_ARM] ? MTS_WAIT : MTS_IDLE;
            end else if (ctrl_reg[`MTS_CTRL_TIMED]) begin
              delay_left_reg <= interval_reg;
              state_reg <= MTS_SPACE;
            end else begin
              delay_left_reg <= eff_delay_reg;
              state_reg <= MTS_DELAY;
            end
          end
        end
        default: state_reg <= MTS_IDLE;
      endcase
    end
  end

  // Complete pulse after every measurement, pre-trigger ones included
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comp_cnt_reg <= 8'h00;
      comp_level_reg <= 1'b1;
    end else begin
      if (done_meas || (state_reg == MTS_WAIT && pre_busy_reg && sample_done)) begin
        comp_cnt_reg <= 8'(`MTS_COMP_PULSE_CYCLES);
      end else if (comp_cnt_reg != 8'h00) begin
        comp_cnt_reg <= comp_cnt_reg - 8'h01;
      end
      comp_level_reg <= ctrl_reg[`MTS_CTRL_COMP_FALL] ^ (comp_cnt_reg > 8'h01
                        || done_meas || (state_reg == MTS_WAIT && pre_busy_reg && sample_done));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waiting_reg <= 1'b0;
    end else begin
      waiting_reg <= (state_reg == MTS_WAIT) && ctrl_reg[`MTS_CTRL_ARM] && (src == MTS_SRC_EXT);
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign measurement_complete_output = comp_level_reg;
  assign waiting_for_trigger = waiting_reg;
  assign sample_start = start_reg;
  assign sample_pretrigger = start_pre_reg;
endmodule // mts_top

// *** sim/mts_chk.sv ***
`timescale 1ns/1ps
module mts_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Read channel
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  // Trigger and converter
  input wire logic measurement_complete_output,
  input wire logic waiting_for_trigger,
  input wire logic sample_start,
  input wire logic sample_pretrigger,
  input wire logic sample_done
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_start_pulse; sample_start |=> !sample_start [*8]; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not a lone pulse");
  property p_comp_after_done; sample_done |=> $changed(measurement_complete_output); endproperty
  a_comp_after_done: assert property (p_comp_after_done) else $error("no complete pulse");
  property p_comp_hold; sample_done ##1 1'b1 |=> $stable(measurement_complete_output) [*8]; endproperty
  a_comp_hold: assert property (p_comp_hold) else $error("complete pulse too short");
  // A pulse near 1000 ns keeps slow switching devices able to see it
  property p_comp_width;
    sample_done ##1 $changed(measurement_complete_output) |-> ##[100:140] $changed(measurement_complete_output);
  endproperty
  a_comp_width: assert property (p_comp_width) else $error("complete pulse never ends");
  property p_wait_no_start; sample_start && !sample_pretrigger |-> !waiting_for_trigger; endproperty
  a_wait_no_start: assert property (p_wait_no_start) else $error("waiting during sample");
  property p_reset_idle; $rose(aresetn) |-> measurement_complete_output && !waiting_for_trigger; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("bad level after reset");
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_decerr; s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1C |=> s_axi_rresp == 2'h3; endproperty
  a_rd_decerr: assert property (p_rd_decerr) else $error("unmapped read not refused");
  c_done: cover property (sample_done);
  c_wait_left: cover property ($fell(waiting_for_trigger));
  c_decerr: cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
endmodule // mts_chk
bind mts_top mts_chk u_chk (.*);

// *** sim/mts_far_model.sv ***
`timescale 1ns/1ps
module mts_far_model (
  // Clock
  input wire logic aclk,
  // Converter side
  input wire logic sample_start,
  input wire logic slow,
  output logic sample_done,
  // Switching device side
  input wire logic step,
  output logic ext_trigger_in
);
  int busy = 0;
  initial sample_done = 1'b0;
  initial ext_trigger_in = 1'b1;
  // Conversions outlast the complete pulse, so pulses never overlap
  always @(posedge aclk) begin
    sample_done <= (busy == 1);
    if (sample_start) busy <= slow ? 200 : 130;
    else if (busy != 0) busy <= busy - 1;
    if (step) ext_trigger_in <= !ext_trigger_in;
  end
endmodule // mts_far_model

// *** sim/mts_tb_top.sv ***
`timescale 1ns/1ps
module mts_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic slow = 1'b0, step = 1'b0;
  logic [2:0] autorange_range = 3'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ext_trigger_in;
  logic measurement_complete_output, waiting_for_trigger, sample_start, sample_pretrigger, sample_done;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, dat;
  int errors = 0, n_checks = 0, cyc = 0, n_start = 0, exp_start = 0, cnt = 0, seed = 32'h6120_c64d;
  // Settings and the delay in microseconds they must give
  logic [11:0] cfg_tab [21] = '{12'h200, 12'h100, 12'h000, 12'h201, 12'h101, 12'h002, 12'h042, 12'h252, 12'h243,
    12'h063, 12'h103, 12'h004, 12'h005, 12'h405, 12'h805, 12'h006, 12'h406, 12'h806, 12'h207, 12'h008, 12'h009};
  int dly_tab [21] = '{160, 130, 100, 1500, 1000, 80, 5000, 84000, 15000, 100000, 1000, 0, 2500000, 625000, 25000,
    1660000, 250000, 25000, 160, 1000, 1000000};
  mts_top #(.US_TICK_CYCLES(32'h0000_0001)) DUT (.*);
  mts_far_model u_far (.*);
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (sample_start === 1'b1) n_start <= n_start + 1;
    if (cyc == 40000) begin
      errors = errors + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_checks = n_checks + 1;
    if (got !== want) begin
      errors = errors + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] want);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0000_0000, s_axi_bresp}, {30'h0000_0000, want});
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    dat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] want);
    rd(a);
    chk(dat, want);
  endtask
  task automatic pulse();
    @(posedge aclk);
    step <= 1'b1;
    @(posedge aclk);
    step <= 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk(8'h00, 32'h0000_0030);
    rchk(8'h04, 32'h0000_0001);
    rd(8'h20);
    chk({30'h0000_0000, rsp}, 32'h0000_0003);
    wchk(8'h08, 32'h0000_0005, 2'h2);
    wchk(8'h04, 32'h000F_4241, 2'h2);
    wchk(8'h04, 32'h000F_4240, 2'h0);
    wchk(8'h08, 32'h000F_4240, 2'h2);
    wchk(8'h0C, 32'hD693_A401, 2'h2);
    wchk(8'h0C, 32'hD693_A400, 2'h0);
    // Partial strobes are refused; the sticky flag then clears on a one written
    s_axi_wstrb <= 4'h3;
    wchk(8'h1C, 32'h0000_0001, 2'h2);
    s_axi_wstrb <= 4'hF;
    rd(8'h14);
    chk(dat & 32'h0000_0001, 32'h0000_0001);
    wchk(8'h14, 32'h0000_0001, 2'h0);
    rd(8'h14);
    chk(dat & 32'h0000_0001, 32'h0000_0000);
    foreach (cfg_tab[i]) begin
      wchk(8'h10, cfg_tab[i], 2'h0);
      rchk(8'h18, dly_tab[i]);
    end
    wchk(8'h0C, 32'h0000_0007, 2'h0);
    wchk(8'h00, 32'h0000_00B0, 2'h0);
    rchk(8'h18, 32'h0000_0007);
    wchk(8'h00, 32'h0000_0130, 2'h0);
    rchk(8'h18, 32'h0000_C350);
    cnt = 2 + ($random(seed) & 1);
    slow <= 1'($random(seed));
    wchk(8'h0C, 32'h0000_0000, 2'h0);
    wchk(8'h04, cnt, 2'h0);
    wchk(8'h00, 32'h0000_00B9, 2'h0);
    rchk(8'h00, 32'h0000_00B9);
    chk(waiting_for_trigger, 32'h0000_0001);
    pulse();
    repeat (50) if (n_start == 0) @(posedge aclk);
    // Two falling edges land mid-burst; only one may be kept
    repeat (4) pulse();
    exp_start = 2 * cnt;
    repeat (4000) if (n_start < exp_start) @(posedge aclk);
    repeat (400) @(posedge aclk);
    chk(n_start, exp_start);
    chk(waiting_for_trigger, 32'h0000_0001);
    pulse();
    repeat (400) @(posedge aclk);
    chk(n_start, exp_start);
    // Bus source: one strobe gives one burst
    wchk(8'h00, 32'h0000_00B5, 2'h0);
    wchk(8'h00, 32'h0000_00B7, 2'h0);
    exp_start = exp_start + cnt;
    repeat (4000) if (n_start < exp_start) @(posedge aclk);
    repeat (400) @(posedge aclk);
    chk(n_start, exp_start);
    // Immediate source bursts on its own; a disarm still lets the burst finish
    wchk(8'h00, 32'h0000_00B1, 2'h0);
    repeat (1000) @(posedge aclk);
    wchk(8'h00, 32'h0000_00B0, 2'h0);
    repeat (1000) @(posedge aclk);
    chk((n_start > exp_start) && ((n_start - exp_start) % cnt == 0), 32'h0000_0001);
    stop_test();
  end
endmodule // mts_tb_top
